// ==== include/pie_pkg.sv ====
package pie_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int PIE_NUM_IRQ = 8;
  localparam int PIE_NUM_USER = 4;
  localparam int PIE_NUM_TIMER = 4;
  localparam int PIE_VEC_W = 3;
  localparam int PIE_ADDR_W = 4;

  // ----------------------------------------------------------------
  // Register word addresses (Avalon word index)
  // ----------------------------------------------------------------
  localparam logic [3:0] PIE_REG_VECTOR = 4'h0;
  localparam logic [3:0] PIE_REG_PENDING = 4'h1;
  localparam logic [3:0] PIE_REG_MASK = 4'h2;
  localparam logic [3:0] PIE_REG_EDGE = 4'h3;
  localparam logic [3:0] PIE_REG_STATUS = 4'h4;
  localparam logic [3:0] PIE_REG_IRQ_MASK = 4'h5;

  // ----------------------------------------------------------------
  // Vector register fields and reset values
  // ----------------------------------------------------------------
  localparam int PIE_VEC_LSB = 0;
  localparam int PIE_VEC_VALID_BIT = 8;
  localparam logic [7:0] PIE_MASK_RST = 8'hFF;
  localparam logic [7:0] PIE_EDGE_RST = 8'h00;
  localparam logic [7:0] PIE_IRQ_MASK_RST = 8'h00;

  // Status bits of the interrupt register
  localparam int PIE_ST_SERVICED = 0;
  localparam int PIE_ST_EMPTY_READ = 1;
  localparam int PIE_ST_W = 2;

  // Read data for unmapped addresses
  localparam logic [31:0] PIE_UNMAPPED_RD = 32'h0000_0000;

  typedef enum logic [0:0] {
    PIE_BUS_IDLE = 1'b0,
    PIE_BUS_ACK = 1'b1
  } pie_bus_e;

endpackage

// ==== design/pie_prio_enc.sv ====
`timescale 1ns/10ps
module pie_prio_enc
  import pie_pkg::*;
(
  input wire logic [7:0] req, // Unmasked pending requests
  output logic [2:0] vec, // Winning index
  output logic valid // Any request present
);

  // ----------------------------------------------------------------
  // Priority search
  // ----------------------------------------------------------------
  // eight priority levels
  always_comb begin
    vec = 3'h0;
    valid = 1'b0;
    for (int i = PIE_NUM_IRQ - 1; i >= 0; i--) begin
      if (req[i]) begin
        vec = 3'(i);
        valid = 1'b1;
      end
    end
  end

endmodule // pie_prio_enc

// ==== design/pie_ctrl.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Contract
// - Eight-level priority encoder resolves pending requests
// - Four inputs come from peripheral logic array
// - Four inputs are timer terminal counts
// - Per-input mask blocks encoder contribution
// - Per-input level or edge detection
// - Host reads a 3-bit vector of winner
// - Vector read clears serviced pending request
// ----------------------------------------------------------------
module pie_ctrl
  import pie_pkg::*;
(
  input wire logic mclk, // System clock, 100 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic [3:0] user_irq, // Conditions from peripheral_logic_array
  input wire logic [3:0] timer_tc, // Terminal count flags of timers 0..3
  input wire logic [3:0] avs_address, // Word address
  input wire logic avs_read, // Read strobe
  input wire logic avs_write, // Write strobe
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic irq_out, // Level interrupt to host
  output logic [2:0] vector_out, // Current vector
  output logic vector_valid // Vector names a real request
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pie_bus_e bus;
    logic [31:0] rdata;
    logic [7:0] src_d;
    logic [7:0] pend;
    logic [7:0] mask;
    logic [7:0] edge_sel;
    logic [PIE_ST_W-1:0] status;
    logic [PIE_ST_W-1:0] irq_mask;
    logic [2:0] vec;
    logic vec_ok;
  } pie_state_s;

  pie_state_s st_r;
  pie_state_s st_nxt;

  logic [7:0] src;
  logic [7:0] eligible;
  logic [2:0] enc_vec;
  logic enc_valid;
  logic acc;
  logic wr_hit;
  logic rd_hit;

  // Apply byte lane 0 to an 8-bit field
  function automatic logic [7:0] pie_wr8(input logic [7:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
    pie_wr8 = be[0] ? d[7:0] : old;
  endfunction

  // ----------------------------------------------------------------
  // Source assembly
  // ----------------------------------------------------------------
  // user inputs low
  assign src = {timer_tc, user_irq};

  assign eligible = st_r.pend & ~st_r.mask;

  pie_prio_enc u_enc (
    .req(eligible),
    .vec(enc_vec),
    .valid(enc_valid)
  );

  // One wait cycle per access; a read samples at the first edge so its data
  // stands when waitrequest drops, a write commits only on the completing edge
  assign acc = (avs_read | avs_write) & (st_r.bus == PIE_BUS_IDLE);
  assign wr_hit = avs_write & (st_r.bus == PIE_BUS_ACK);
  assign rd_hit = avs_read & acc;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] set_v;
    logic [7:0] clr_v;
    logic [PIE_ST_W-1:0] ev;
    logic [PIE_ST_W-1:0] w1c;
    set_v = 8'h00;
    clr_v = 8'h00;
    ev = '0;
    w1c = '0;
    st_nxt = st_r;
    st_nxt.src_d = src;
    st_nxt.bus = acc ? PIE_BUS_ACK : PIE_BUS_IDLE;

    for (int i = 0; i < PIE_NUM_IRQ; i++) begin
      if (st_r.edge_sel[i]) begin
        set_v[i] = src[i] & ~st_r.src_d[i];
      end else begin
        set_v[i] = src[i];
      end
    end

    // Register reads and writes
    if (rd_hit) begin
      unique case (avs_address)
        PIE_REG_VECTOR: begin
          st_nxt.rdata = 32'h0;
          st_nxt.rdata[PIE_VEC_LSB +: PIE_VEC_W] = enc_vec;
          st_nxt.rdata[PIE_VEC_VALID_BIT] = enc_valid;
          if (enc_valid) begin
            clr_v[enc_vec] = 1'b1;
            ev[PIE_ST_SERVICED] = 1'b1;
          end else begin
            ev[PIE_ST_EMPTY_READ] = 1'b1;
          end
        end
        PIE_REG_PENDING: st_nxt.rdata = {24'h0, st_r.pend};
        PIE_REG_MASK: st_nxt.rdata = {24'h0, st_r.mask};
        PIE_REG_EDGE: st_nxt.rdata = {24'h0, st_r.edge_sel};
        PIE_REG_STATUS: st_nxt.rdata = {30'h0, st_r.status};
        PIE_REG_IRQ_MASK: st_nxt.rdata = {30'h0, st_r.irq_mask};
        default: st_nxt.rdata = PIE_UNMAPPED_RD;
      endcase
    end

    if (wr_hit) begin
      unique case (avs_address)
        PIE_REG_MASK: st_nxt.mask = pie_wr8(st_r.mask, avs_writedata, avs_byteenable);
        PIE_REG_EDGE: st_nxt.edge_sel = pie_wr8(st_r.edge_sel, avs_writedata, avs_byteenable);
        PIE_REG_STATUS: w1c = avs_byteenable[0] ? avs_writedata[PIE_ST_W-1:0] : '0;
        PIE_REG_IRQ_MASK: begin
          if (avs_byteenable[0]) begin
            st_nxt.irq_mask = avs_writedata[PIE_ST_W-1:0];
          end
        end
        default: ;
      endcase
    end

    // Set beats clear so a fresh event is never lost
    st_nxt.pend = (st_r.pend & ~clr_v) | set_v;
    st_nxt.status = (st_r.status & ~w1c) | ev;
    st_nxt.vec = enc_vec;
    st_nxt.vec_ok = enc_valid;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= '{bus: PIE_BUS_IDLE, rdata: 32'h0, src_d: 8'h00, pend: 8'h00,
                mask: PIE_MASK_RST, edge_sel: PIE_EDGE_RST, status: '0,
                irq_mask: '0, vec: 3'h0, vec_ok: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Waitrequest high only in the first cycle of an access
  assign avs_waitrequest = (avs_read | avs_write) & (st_r.bus == PIE_BUS_IDLE);
  assign avs_readdata = st_r.rdata;
  assign vector_out = st_r.vec;
  assign vector_valid = st_r.vec_ok;
  // Host interrupt: an unmasked pending request, or an unmasked status event
  assign irq_out = st_r.vec_ok | (|(st_r.status & st_r.irq_mask));

endmodule // pie_ctrl

// ==== verification/pie_src_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Source logic model
// ----------------------------------------------------------------
module pie_src_model
  import pie_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic [7:0] cond, // Wanted conditions, bit = input
  output logic [3:0] user_irq, // To user inputs 0..3
  output logic [3:0] timer_tc // To timer inputs 4..7
);
  // Registered so changes land clear of the sampling edge
  // array logic and counters
  always_ff @(posedge mclk) begin
    user_irq <= cond[3:0];
    timer_tc <= cond[7:4];
  end
endmodule // pie_src_model

// ==== verification/pie_ctrl_assertions.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module pie_ctrl_chk
  import pie_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic reset, // Sync reset
  input wire logic [3:0] avs_address, // Address
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Stall
  input wire logic irq_out, // Interrupt
  input wire logic [2:0] vector_out, // Vector
  input wire logic vector_valid // Vector valid
);
  // Read accepted at this edge
  logic acc;
  assign acc = avs_read && !avs_waitrequest;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  chk_wait_single: assert property (
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("bad wait");
  chk_rd_stable: assert property (
    !(avs_read && avs_waitrequest) |=> $stable(avs_readdata)) else $error("readdata moved");
  chk_vec_fields: assert property (
    acc && avs_address == PIE_REG_VECTOR |-> avs_readdata[31:9] == 0 && avs_readdata[7:3] == 0)
    else $error("vector field junk");
  chk_unmapped_zero: assert property (
    acc && avs_address > PIE_REG_IRQ_MASK |-> avs_readdata == PIE_UNMAPPED_RD)
    else $error("unmapped data");
  chk_irq_valid: assert property (vector_valid |-> irq_out) else $error("irq low");
  chk_reset_quiet: assert property (disable iff (1'b0)
    reset |=> !irq_out && avs_readdata == 32'h0) else $error("reset outputs");
  chk_reset_vec: assert property (disable iff (1'b0)
    reset |=> !vector_valid && vector_out == 3'h0) else $error("reset vector");
  // All inputs masked from reset, so nothing can win early
  chk_masked_start: assert property (
    $fell(reset) |-> (!vector_valid && !irq_out) [*3]) else $error("early request");
  cover property (vector_valid);
  cover property (irq_out && !vector_valid);
  cover property (acc && avs_address == PIE_REG_VECTOR);
endmodule // pie_ctrl_chk

bind pie_ctrl pie_ctrl_chk u_chk (.mclk, .reset, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .irq_out, .vector_out, .vector_valid);

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Bench
// ----------------------------------------------------------------
module tb_top
  import pie_pkg::*;
();
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic mclk, reset, avs_read, avs_write, irq_out, vector_valid, avs_waitrequest;
  logic [3:0] avs_address, user_irq, timer_tc;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [2:0] vector_out;
  logic [7:0] cond;
  int mismatches = 0, checks_done = 0, cyc = 0;
  pie_src_model SRC (.mclk(mclk), .cond(cond), .user_irq(user_irq), .timer_tc(timer_tc));
  pie_ctrl DUT (.mclk(mclk), .reset(reset), .user_irq(user_irq), .timer_tc(timer_tc),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_out(irq_out), .vector_out(vector_out),
    .vector_valid(vector_valid));
  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard, whole run needs well under this
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      end_of_test();
    end
  end
  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    // Only the hang guard ends a wait that never completes
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    chk(q & m, exp);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  // Main sequence
  initial begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    cond = 8'h00;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    rc(PIE_REG_MASK, 32'hFF, ALL);
    rc(PIE_REG_EDGE, 32'h00, ALL);
    rc(PIE_REG_IRQ_MASK, 32'h00, ALL);
    rc(4'hF, 32'h0, ALL);
    $display("test reset done");
    // All eight pending, drained strictly by priority
    wr(PIE_REG_MASK, 32'h00);
    cond <= 8'hFF;
    repeat (3) @(posedge mclk);
    cond <= 8'h00;
    for (int i = 0; i < 8; i++) rc(PIE_REG_VECTOR, 32'h100 | 32'(i), ALL);
    rc(PIE_REG_VECTOR, 32'h0, 32'h100);
    chk({31'h0, irq_out}, 32'h0);
    rc(PIE_REG_STATUS, 32'h3, ALL);
    wr(PIE_REG_IRQ_MASK, 32'h2);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq_out}, 32'h1);
    wr(PIE_REG_STATUS, 32'h3);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq_out}, 32'h0);
    rc(PIE_REG_STATUS, 32'h0, ALL);
    $display("test priority done");
    // Input 0 masked, input 1 must win
    wr(PIE_REG_MASK, 32'h01);
    cond <= 8'h03;
    repeat (3) @(posedge mclk);
    cond <= 8'h00;
    @(posedge mclk);
    chk({28'h0, vector_valid, vector_out}, 32'h9);
    rc(PIE_REG_VECTOR, 32'h101, ALL);
    rc(PIE_REG_PENDING, 32'h01, ALL);
    // Edge mode fires once for a held level
    wr(PIE_REG_EDGE, 32'hFF);
    cond <= 8'h10;
    repeat (3) @(posedge mclk);
    rc(PIE_REG_VECTOR, 32'h104, ALL);
    rc(PIE_REG_VECTOR, 32'h0, 32'h100);
    $display("test mask edge done");
    end_of_test();
  end
endmodule // tb_top
